/* src/srap_port.sv */
`timescale 1ns/1ps
`default_nettype none
module srap_port
    import srap_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_data_pin,
    output logic serial_out_data_pin_oe,
    input wire logic three_wire,
    input wire logic lsb_first,
    input wire logic [DATA_W-1:0] rd_data,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_strobe,
    output logic rd_strobe,
    output logic busy
);
    // ------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------
    typedef struct packed {
        srap_state_t st;
        logic [CNT_W-1:0] cnt;         // bits done in this phase
        logic [CNT_W-1:0] nbits;       // bits in data phase
        logic [BYTE_W-1:0] instr;      // instruction shift
        logic rd;                      // current cycle reads
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] sh;         // data shift path
        logic [3:0] rsync;             // clocks counted while deselected
        logic out_bit;
        logic sdio_oe;
        logic sdo_oe;
        logic [DATA_W-1:0] wdat;
        logic wstb;
        logic rstb;
        logic bsy;                     // data phase under way
    } srap_core_t;
    srap_core_t r;
    srap_core_t next_r;

    srap_pins_if pins ();

    // register width in bytes by address; only whole registers move
    function automatic logic [2:0] reg_len(input logic [ADDR_W-1:0] a);
        if (a == ADDR_FREQ_WORD) begin
            reg_len = LEN_FREQ_WORD;
        end else if (a == ADDR_AMPL_SCALE) begin
            reg_len = LEN_AMPL_SCALE;
        end else begin
            reg_len = LEN_DEFAULT;
        end
    endfunction : reg_len

    // left-justify register bits so msb-first shifts from the top
    function automatic logic [DATA_W-1:0] justify(input logic [DATA_W-1:0] d,
                                                  input logic [2:0] len);
        justify = d << (DATA_W - BYTE_W * int'(len));
    endfunction : justify

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    srap_sampler u_smp (
        .mclk(mclk),
        .nrst(nrst),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdio_in(sdio_in),
        .pins(pins.src)
    );

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    always_comb begin
        logic [BYTE_W-1:0] ins;
        logic [2:0] len;
        ins = '0;
        len = '0;
        next_r = r;
        next_r.wstb = 1'b0;
        next_r.rstb = 1'b0;
        if (pins.cs_n) begin
            // deselected: outputs float, cycle held until RESYNC_EDGES clocks drop it
            next_r.sdio_oe = 1'b0;
            next_r.sdo_oe = 1'b0;
            if (pins.sclk_rise) begin
                if (r.rsync == 4'(RESYNC_EDGES - 1)) begin
                    // resync: drop whatever cycle was in flight
                    next_r.st = SRAP_INSTR;
                    next_r.cnt = '0;
                    next_r.rd = 1'b0;
                    next_r.rsync = '0;
                end else begin
                    next_r.rsync = r.rsync + 4'h1;
                end
            end
        end else begin
            next_r.rsync = '0;
            // drive enables only during a read data phase
            next_r.sdio_oe = (r.st == SRAP_DATA) && r.rd && three_wire;
            next_r.sdo_oe = (r.st == SRAP_DATA) && r.rd && !three_wire;
            if (pins.sclk_rise) begin
                case (r.st)
                    SRAP_INSTR: begin
                        // instruction bits in chosen order
                        if (lsb_first) begin
                            ins = {pins.sdio_in, r.instr[BYTE_W-1:1]};
                        end else begin
                            ins = {r.instr[BYTE_W-2:0], pins.sdio_in};
                        end
                        next_r.instr = ins;
                        next_r.cnt = r.cnt + 6'h1;
                        if (r.cnt == CNT_W'(INSTR_BITS - 1)) begin
                            len = reg_len(ins[ADDR_W-1:0]);
                            next_r.rd = ins[RW_BIT];
                            next_r.addr = ins[ADDR_W-1:0];
                            next_r.nbits = CNT_W'(BYTE_W * int'(len));
                            next_r.cnt = '0;
                            next_r.st = SRAP_DATA;
                            if (ins[RW_BIT]) begin
                                // flag the read; the word is loaded next cycle
                                next_r.rstb = 1'b1;
                            end
                            next_r.sh = '0;
                        end
                    end
                    SRAP_DATA: begin
                        if (!r.rd) begin
                            // write bits: msb-first fills from the bottom,
                            // lsb-first enters at the top of the register
                            if (lsb_first) begin
                                next_r.sh = {pins.sdio_in, r.sh[DATA_W-1:1]};
                            end else begin
                                next_r.sh = {r.sh[DATA_W-2:0], pins.sdio_in};
                            end
                        end else begin
                            // read: advance after the host took the bit
                            next_r.sh = lsb_first ? (r.sh >> 1) : (r.sh << 1);
                        end
                        next_r.cnt = r.cnt + 6'h1;
                        if (r.cnt == r.nbits - 6'h1) begin
                            // last bit of the register closes the cycle
                            next_r.st = SRAP_INSTR;
                            next_r.cnt = '0;
                            next_r.sdio_oe = 1'b0;
                            next_r.sdo_oe = 1'b0;
                            if (!r.rd) begin
                                next_r.wstb = 1'b1;
                                next_r.wdat = lsb_first
                                    ? (next_r.sh >> (DATA_W - int'(r.nbits)))
                                    : next_r.sh;
                            end
                        end
                    end
                    default: begin
                        next_r.st = SRAP_INSTR;
                        next_r.cnt = '0;
                    end
                endcase
            end
            // present the current bit on the falling edge
            if (pins.sclk_fall && r.st == SRAP_DATA && r.rd) begin
                next_r.out_bit = lsb_first ? r.sh[0] : r.sh[DATA_W-1];
            end
        end
        // rd_data follows reg_addr, which carries the new address only now;
        // loading a cycle late is safe, the falling edge is half a period away
        if (r.rstb) begin
            next_r.sh = lsb_first ? rd_data : justify(rd_data, reg_len(r.addr));
        end
        // busy as its own flop so the pin comes straight from a register
        next_r.bsy = (next_r.st == SRAP_DATA);
    end

    // register the whole state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= '{st: SRAP_INSTR, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------
    assign sdio_out = r.out_bit;
    assign sdio_oe = r.sdio_oe;
    assign serial_out_data_pin = r.out_bit;
    assign serial_out_data_pin_oe = r.sdo_oe;
    assign reg_addr = r.addr;
    assign wr_data = r.wdat;
    assign wr_strobe = r.wstb;
    assign rd_strobe = r.rstb;
    assign busy = r.bsy;
endmodule : srap_port
`default_nettype wire

/* include/srap_pkg.sv */
package srap_pkg;
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam int INSTR_BITS = 8;          // instruction byte length
    localparam int RW_BIT = 7;              // direction bit, 1 = read
    localparam int ADDR_W = 5;              // register address width
    localparam int NREG = 32;               // address space
    localparam int DATA_W = 32;             // widest register, in bits
    localparam int BYTE_W = 8;
    localparam int RESYNC_EDGES = 8;        // clocks with select high that reset the port
    localparam int CNT_W = 6;               // bit counter width
    // ------------------------------------------------------------
    // register widths in bytes; default for unlisted addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FREQ_WORD = 5'h0a; // frequency_tuning_word
    localparam logic [ADDR_W-1:0] ADDR_AMPL_SCALE = 5'h0b; // amplitude_scale_factor
    localparam logic [2:0] LEN_FREQ_WORD = 3'h4;
    localparam logic [2:0] LEN_AMPL_SCALE = 3'h3;
    localparam logic [2:0] LEN_DEFAULT = 3'h2;
    // ------------------------------------------------------------
    // port states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRAP_INSTR = 2'b00,
        SRAP_DATA = 2'b01
    } srap_state_t;
endpackage : srap_pkg

/* include/srap_pins_if.sv */
`timescale 1ns/1ps
`default_nettype none
// cleaned link pins travelling from the sampler to the port core
interface srap_pins_if;
    logic sclk_rise;  // rising link clock edge, one cycle
    logic sclk_fall;  // falling link clock edge, one cycle
    logic cs_n;       // filtered select, active low
    logic sdio_in;    // filtered data in
    modport src (output sclk_rise, output sclk_fall, output cs_n, output sdio_in);
    modport dst (input sclk_rise, input sclk_fall, input cs_n, input sdio_in);
endinterface : srap_pins_if
`default_nettype wire

/* src/srap_sampler.sv */
`timescale 1ns/1ps
`default_nettype none
module srap_sampler
    import srap_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    srap_pins_if.src pins
);
    // ------------------------------------------------------------
    // state: three stages per pin, stable level per pin
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ck;
        logic [2:0] cs;
        logic [2:0] di;
        logic ck_lvl;
        logic cs_lvl;
        logic di_lvl;
        logic rise;
        logic fall;
        logic [1:0] fill;   // clocks since reset, saturating
        logic primed;       // every stage holds a real pin sample
    } srap_smp_t;
    srap_smp_t s;
    srap_smp_t next_s;

    // stage 0 feeds stage 1 only; levels follow when stages 1 and 2 agree
    always_comb begin
        next_s = s;
        next_s.ck = {s.ck[1:0], sclk};
        next_s.cs = {s.cs[1:0], cs_n};
        next_s.di = {s.di[1:0], sdio_in};
        if (s.ck[2] == s.ck[1]) begin
            next_s.ck_lvl = s.ck[2];
        end
        if (s.cs[2] == s.cs[1]) begin
            next_s.cs_lvl = s.cs[2];
        end
        if (s.di[2] == s.di[1]) begin
            next_s.di_lvl = s.di[2];
        end
        // count the first clocks after reset until the stages are filled
        if (!(&s.fill)) begin
            next_s.fill = s.fill + 2'h1;
        end
        next_s.primed = &s.fill;
        // edges of the agreed clock level, none while the stages still fill,
        // so a link clock idling high gives no false edge after reset
        next_s.rise = next_s.ck_lvl & ~s.ck_lvl & s.primed;
        next_s.fall = ~next_s.ck_lvl & s.ck_lvl & s.primed;
    end

    // register the whole state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= '{ck: 3'h0, cs: 3'h7, di: 3'h0, ck_lvl: 1'b0, cs_lvl: 1'b1,
                   di_lvl: 1'b0, rise: 1'b0, fall: 1'b0, fill: 2'h0, primed: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign pins.sclk_rise = s.rise;
    assign pins.sclk_fall = s.fall;
    assign pins.cs_n = s.cs_lvl;
    // data level at the edge; rise and data pass the same stages, so data set up before the rise is taken
    assign pins.sdio_in = s.di_lvl;
endmodule : srap_sampler
`default_nettype wire

/* tb/srap_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port protocol checker
// ------------------------------------------------
module srap_port_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic three_wire,
    input wire logic sdio_oe,
    input wire logic serial_out_data_pin,
    input wire logic serial_out_data_pin_oe,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic busy
);
    logic [2:0] since_fall; // mclk cycles since the link clock fell
    logic oe_any; // either data pin driven
    assign oe_any = sdio_oe | serial_out_data_pin_oe;
    // saturating count; an output bit may only move soon after a fall
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) since_fall <= 3'h7;
        else if ($fell(sclk)) since_fall <= 3'h0;
        else if (since_fall != 3'h7) since_fall <= since_fall + 3'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_drive; ##[1:2] oe_any; endsequence // read word starts driving
    sequence s_done; ##[0:1] !busy; endsequence // data phase closes
    // filter latency plus output register, so seven quiet samples
    a_float_deselect: assert property (cs_n [*7] |-> !oe_any)
        else $error("data pin driven while deselected");
    a_oe_shared: assert property (sdio_oe |-> three_wire)
        else $error("shared pin driven in split mode");
    a_oe_split: assert property (serial_out_data_pin_oe |-> !three_wire)
        else $error("out pin driven in shared mode");
    a_wr_pulse: assert property (wr_strobe |=> !wr_strobe)
        else $error("write strobe longer than one cycle");
    a_wr_ends: assert property (wr_strobe |-> s_done)
        else $error("busy stays after last write byte");
    a_rd_drive: assert property (rd_strobe |-> s_drive)
        else $error("read word loaded but pin not driven");
    a_oe_busy: assert property ($rose(oe_any) |-> busy)
        else $error("pin driven outside data phase");
    a_bit_fall: assert property ($changed(serial_out_data_pin) && serial_out_data_pin_oe
        && $past(serial_out_data_pin_oe) |-> since_fall < 3'h7)
        else $error("out bit moved away from a falling edge");
endmodule : srap_port_chk
bind srap_port srap_port_chk u_chk (.mclk, .nrst, .sclk, .cs_n, .three_wire, .sdio_oe,
    .serial_out_data_pin, .serial_out_data_pin_oe, .wr_strobe, .rd_strobe, .busy);
`default_nettype wire

/* tb/srap_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// host master model, link clock idles high
// ------------------------------------------------
module srap_host (
    input wire logic mclk,
    input wire logic three_wire,
    input wire logic lsb_first,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_out_data_pin,
    input wire logic serial_out_data_pin_oe,
    output logic sclk,
    output logic cs_n,
    output logic sdio_in
);
    logic hd = 1'b0; // last bit put out by the host
    logic hoe = 1'b0; // host drives the data line
    logic pin; // level on the host receive line
    initial sclk = 1'b1;
    initial cs_n = 1'b1;
    // a released line has no pull, so it shows the inverse of the last bit
    assign sdio_in = hoe ? hd : ((three_wire && sdio_oe) ? sdio_out : ~hd);
    assign pin = three_wire ? sdio_in : (serial_out_data_pin_oe ? serial_out_data_pin : ~hd);
    // one link period: fall, set up, rise, sample mid high phase
    task automatic clk_bit(input logic d, output logic q);
        sclk = 1'b0;
        hd = d;
        repeat (4) @(negedge mclk);
        sclk = 1'b1;
        repeat (2) @(negedge mclk);
        q = pin;
        repeat (2) @(negedge mclk);
    endtask : clk_bit
    // whole frame; gap is the data bit where select is lifted for a while
    task automatic xfer(input logic [7:0] ins, input int nb, input int gap,
        input logic [31:0] w, output logic [31:0] r);
        int k;
        logic q;
        @(negedge mclk);
        cs_n = 1'b0;
        hoe = 1'b1;
        r = 32'h0;
        for (int i = 0; i < 8; i++) clk_bit(ins[lsb_first ? i : 7 - i], q);
        hoe = ~ins[7];
        for (int i = 0; i < nb * 8; i++) begin
            if (i == gap) begin
                cs_n = 1'b1;
                repeat (3) clk_bit(1'b1, q);
                cs_n = 1'b0;
            end
            k = lsb_first ? i : nb * 8 - 1 - i;
            clk_bit(w[k], q);
            r[k] = q;
        end
        hoe = 1'b0;
        cs_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask : xfer
    // broken frame, then eight clocks with select high
    task automatic resync(input int nbits);
        logic q;
        @(negedge mclk);
        cs_n = 1'b0;
        repeat (nbits) clk_bit(1'b1, q);
        cs_n = 1'b1;
        repeat (8) clk_bit(1'b0, q);
        repeat (8) @(negedge mclk);
    endtask : resync
endmodule : srap_host
`default_nettype wire

/* tb/serial_register_access_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
// ------------------------------------------------
// bench top: host model against the port
// ------------------------------------------------
module serial_register_access_port_tb_top
    import srap_pkg::*;
;
    logic mclk, nrst, sclk, cs_n, sdio_in, three_wire, lsb_first, sdio_out, sdio_oe;
    logic serial_out_data_pin, serial_out_data_pin_oe, wr_strobe, rd_strobe, busy;
    logic [DATA_W-1:0] rd_data, wr_data, wr_seen, rd_back;
    logic [ADDR_W-1:0] reg_addr, addr_seen;
    logic [DATA_W-1:0] mem [NREG]; // register file behind the port
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_wr = 0; // write strobes seen
    assign rd_data = mem[reg_addr];
    // register file takes each written word
    always @(posedge mclk) begin
        if (wr_strobe) begin
            mem[reg_addr] <= wr_data;
            wr_seen <= wr_data;
            addr_seen <= reg_addr;
            n_wr++;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    srap_port dut (.mclk, .nrst, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
        .serial_out_data_pin, .serial_out_data_pin_oe, .three_wire, .lsb_first, .rd_data,
        .reg_addr, .wr_data, .wr_strobe, .rd_strobe, .busy);
    srap_host host (.mclk, .three_wire, .lsb_first, .sdio_out, .sdio_oe,
        .serial_out_data_pin, .serial_out_data_pin_oe, .sclk, .cs_n, .sdio_in);
    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // write a register, then read it back with the ignored bits set
    task automatic wr_rd(input logic [4:0] a, input logic [31:0] v, input int gap);
        logic [31:0] r;
        logic [31:0] m;
        int nb;
        nb = (a == ADDR_FREQ_WORD) ? int'(LEN_FREQ_WORD)
            : (a == ADDR_AMPL_SCALE) ? int'(LEN_AMPL_SCALE) : int'(LEN_DEFAULT);
        m = (nb == 4) ? 32'hffffffff : ((32'h1 << (nb * 8)) - 32'h1);
        host.xfer({3'h0, a}, nb, gap, v, r);
        `CHK("wr_addr", a, addr_seen)
        `CHK("wr_data", v & m, wr_seen)
        host.xfer({3'h7, a}, nb, gap, ~v, r);
        `CHK("rd_data", v & m, r)
        `CHK("busy", 1'b0, busy)
    endtask : wr_rd
    initial begin
        nrst = 1'b0;
        three_wire = 1'b0;
        lsb_first = 1'b0;
        for (int i = 0; i < NREG; i++) mem[i] = 32'h0;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        repeat (8) @(negedge mclk);
        // every wire mode and bit order, frames back to back
        for (int md = 0; md < 4; md++) begin
            three_wire = md[0];
            lsb_first = md[1];
            wr_rd(ADDR_FREQ_WORD, 32'h8c3a5e17 + 32'(md), 99);
            wr_rd(ADDR_AMPL_SCALE, 32'h5b7e96c1, 99);
            wr_rd(5'h05, 32'hffff9a4d, 99);
        end
        wr_rd(ADDR_AMPL_SCALE, 32'h00c35a96, 10);
        // read a register other than the one last addressed
        host.xfer({3'h4, ADDR_FREQ_WORD}, int'(LEN_FREQ_WORD), 99, 32'h0, rd_back);
        `CHK("rd_other", 32'h8c3a5e1a, rd_back)
        host.resync(5);
        wr_rd(5'h1f, 32'h0000b2e4, 99);
        `CHK("wr_count", 14, n_wr)
        summarize();
    end
    // watchdog, about five times the expected run
    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
endmodule : serial_register_access_port_tb_top
`default_nettype wire
